//--- cvsg_clkgen.sv
// programmable conversion clock divider
`timescale 1ns/1ns
module cvsg_clkgen (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic on,
  input wire logic [1:0] ref_sel,
  input wire logic [27:0] divider,
  // reference strobes
  input wire logic tick_22,
  input wire logic tick_60,
  // divided clock
  output logic level,
  output logic rise
);

  typedef struct packed {
    logic [27:0] cnt;
    logic level;
    logic rise;
  } cvsg_clk_st_t;

  cvsg_clk_st_t s;
  cvsg_clk_st_t next_s;
  logic tick;

  always_comb begin
    next_s = s;
    next_s.rise = 1'b0;
    case (ref_sel) // RULE_01
      cvsg_pkg::REF_20: tick = 1'b1;
      cvsg_pkg::REF_22: tick = tick_22;
      cvsg_pkg::REF_60: tick = tick_60;
      default: tick = 1'b0;
    endcase
    if (!on) begin
      // RULE_18
      next_s.cnt = 28'h000_0000;
      next_s.level = 1'b0;
    end else if (tick) begin
      // high for the first half of each divided period
      next_s.level = (s.cnt <= (divider >> 1)); // RULE_01
      next_s.rise = (s.cnt == 28'h000_0000);
      // a divider lowered mid-period must still wrap, not run to 2^28
      if (s.cnt >= divider) begin
        next_s.cnt = 28'h000_0000;
      end else begin
        next_s.cnt = s.cnt + 28'h000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;
  assign rise = s.rise;

  // ==========================================================
  // checks
  property p_off_quiet;
    @(posedge clk) disable iff (srst)
    !on |=> !level && s.cnt == 28'h000_0000;
  endproperty
  a_off_quiet: assert property (p_off_quiet) // RULE_18
    else $error("disabled generator not quiet");

  property p_rise_needs_tick;
    @(posedge clk) disable iff (srst)
    rise |-> $past(on) && $past(tick) && level;
  endproperty
  a_rise_needs_tick: assert property (p_rise_needs_tick) // RULE_01
    else $error("divided edge without reference tick");

  property p_fresh_start;
    @(posedge clk) disable iff (srst)
    !on ##1 (on && tick) |=> rise;
  endproperty
  a_fresh_start: assert property (p_fresh_start) // RULE_18
    else $error("enable did not begin a fresh period");

endmodule

//--- cvsg_far_end.sv
// far-side board model: reference strobes and an external clock
`timescale 1ns/1ns
module cvsg_far_end (
  // clock
  input wire logic clk,
  // control
  input wire logic run,
  // far-side signals
  output logic tick_22,
  output logic tick_60,
  output logic ext_clk
);
  logic [2:0] cnt;

  initial begin
    cnt = 3'h0;
    tick_22 = 1'b0;
    tick_60 = 1'b0;
    ext_clk = 1'b0;
  end

  // ==========================================================
  // strobes and clock
  always @(posedge clk) begin
    cnt <= cnt + 3'h1;
    // slower reference skips one cycle in eight
    tick_22 <= (cnt != 3'h0);
    tick_60 <= 1'b1;
    // clock stands low outside a run
    ext_clk <= run & cnt[2];
  end
endmodule

//--- cvsg_framegen.sv
// frame trigger pulse generator
`timescale 1ns/1ns
module cvsg_framegen (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic on,
  input wire logic clk_rise,
  input wire logic [27:0] interval,
  input wire logic [27:0] count,
  // frame pulse, one cycle
  output logic pulse
);

  typedef struct packed {
    cvsg_pkg::cvsg_fg_state_t st;
    logic [27:0] gap;
    logic [27:0] sent;
    logic pulse;
  } cvsg_fg_st_t;

  cvsg_fg_st_t s;
  cvsg_fg_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.pulse = 1'b0;
    case (s.st)
      cvsg_pkg::FG_IDLE: begin
        if (on) begin
          next_s.st = cvsg_pkg::FG_WAIT;
        end
      end
      cvsg_pkg::FG_WAIT: begin
        if (clk_rise) begin
          next_s.pulse = 1'b1; // RULE_06
          next_s.gap = 28'h000_0000;
          next_s.sent = 28'h000_0001;
          if (count == 28'h000_0001) begin
            next_s.st = cvsg_pkg::FG_DONE; // RULE_04
          end else begin
            next_s.st = cvsg_pkg::FG_RUN;
          end
        end
      end
      cvsg_pkg::FG_RUN: begin
        if (clk_rise) begin
          if (s.gap == interval) begin
            next_s.pulse = 1'b1; // RULE_03
            next_s.gap = 28'h000_0000;
            next_s.sent = s.sent + 28'h000_0001;
            // zero count never finishes
            if (count != 28'h000_0000 &&
                next_s.sent == count) begin
              next_s.st = cvsg_pkg::FG_DONE; // RULE_05
            end
          end else begin
            next_s.gap = s.gap + 28'h000_0001;
          end
        end
      end
      default: begin
        next_s.st = cvsg_pkg::FG_DONE;
      end
    endcase
    if (!on) begin
      // RULE_06
      next_s.st = cvsg_pkg::FG_IDLE;
      next_s.pulse = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pulse = s.pulse;

  // ==========================================================
  // checks
  property p_pulse_on_edge;
    @(posedge clk) disable iff (srst)
    pulse |-> $past(clk_rise) && $past(on);
  endproperty
  a_pulse_on_edge: assert property (p_pulse_on_edge) // RULE_06
    else $error("frame pulse off the conversion clock edge");

  property p_single;
    @(posedge clk) disable iff (srst)
    pulse && $past(count) == 28'h000_0001 |-> s.st == cvsg_pkg::FG_DONE;
  endproperty
  a_single: assert property (p_single) // RULE_04
    else $error("single pulse mode kept running");

  property p_stop;
    @(posedge clk) disable iff (srst)
    !on |=> !pulse && s.st == cvsg_pkg::FG_IDLE;
  endproperty
  a_stop: assert property (p_stop) // RULE_06
    else $error("pulses continued after disable");

  property p_spacing;
    @(posedge clk) disable iff (srst)
    on && clk_rise && s.st == cvsg_pkg::FG_RUN && s.gap == interval
      |=> pulse;
  endproperty
  a_spacing: assert property (p_spacing) // RULE_03
    else $error("pulse interval not honoured");

  c_done: cover property (@(posedge clk) s.st == cvsg_pkg::FG_DONE);

endmodule

//--- cvsg_pkg.sv
// shared constants and types of the conversion signal generator
package cvsg_pkg;

  // ==========================================================
  // clock and widths
  localparam int CLK_HZ = 20_000_000;
  localparam int DIV_W = 28;
  localparam int ADDR_W = 12;

  // ==========================================================
  // register offsets
  localparam logic [11:0] OFF_CLK_ONE = 12'h320;
  localparam logic [11:0] OFF_CLK_TWO = 12'h324;
  localparam logic [11:0] OFF_INTERVAL = 12'h32c;
  localparam logic [11:0] OFF_COUNT = 12'h330;
  localparam logic [11:0] OFF_ENABLES = 12'h33c;
  localparam logic [11:0] OFF_ROUTING = 12'h340;
  localparam logic [11:0] OFF_SOURCE = 12'h344;
  localparam logic [11:0] OFF_TIMER = 12'h348;

  // ==========================================================
  // field positions
  localparam int REF_SEL_LSB = 29;
  localparam int FRAME_CLK_SEL_BIT = 29;
  localparam int EN_CLK_ONE_BIT = 0;
  localparam int EN_CLK_TWO_BIT = 1;
  localparam int EN_FRAME_BIT = 8;
  localparam int TIMER_ON_BIT = 31;
  localparam int TIMER_CLK_SEL_BIT = 30;
  localparam int TIMER_EXPIRED_BIT = 29;

  // ==========================================================
  // codes
  localparam logic [1:0] REF_20 = 2'h0;
  localparam logic [1:0] REF_22 = 2'h1;
  localparam logic [1:0] REF_60 = 2'h2;
  localparam logic [1:0] ROUTE_REAR = 2'h2;
  localparam logic [1:0] ROUTE_FRONT = 2'h3;
  localparam logic [1:0] SRC_REAR = 2'h2;
  localparam logic [1:0] SRC_FRONT = 2'h3;

  // ==========================================================
  // reset values
  localparam logic [27:0] DIV_RST = 28'hfff_ffff;
  localparam logic [27:0] INTERVAL_RST = 28'hfff_ffff;
  localparam logic [27:0] COUNT_RST = 28'h000_0000;
  localparam logic [27:0] TIMER_LEN_RST = 28'hfff_ffff;

  typedef enum logic [1:0] {
    FG_IDLE, FG_WAIT, FG_RUN, FG_DONE
  } cvsg_fg_state_t;

endpackage

//--- cvsg_top.sv
// conversion signal generator, routing and frame timer
// ==========================================================
// Functional notes
// RULE_01: clock output is reference over divider plus one
// RULE_02: one bit picks frame clock generator
// RULE_03: pulses spaced interval plus one clocks
// RULE_04: count of one gives single pulse
// RULE_05: count field sets pulses, zero endless
// RULE_06: enable starts at next clock edge
// RULE_07: software also enables associated clock generator
// RULE_08: separate clock enables start together
// RULE_09: software matches references for aligned phases
// RULE_10: routing drives nothing, rear pin, or front
// RULE_11: front line drive enable overrides generator
// RULE_12: sources pick generator, rear or front
// RULE_13: frame event clears and restarts timer
// RULE_14: control bit picks timer counting clock
// RULE_15: timer expires after length plus one
// RULE_16: expiry event sets flag, next frame clears
// RULE_17: both clocks and frame offered to sequencers
// RULE_18: disabled generator held low, counter cleared
// RULE_19: external inputs synchronised before edge detection
`timescale 1ns/1ns
module cvsg_top (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // register port
  input wire logic [11:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic REG_RVALID,
  // reference strobes for the 22.05 and 60 MHz sources
  input wire logic REF_TICK_22,
  input wire logic REF_TICK_60,
  // rear connector
  input wire logic CONVERSION_CLOCK_ONE_PIN_I,
  input wire logic CONVERSION_CLOCK_TWO_PIN_I,
  input wire logic FRAME_PULSE_PIN_I,
  output logic CONVERSION_CLOCK_ONE_PIN_O,
  output logic CONVERSION_CLOCK_ONE_PIN_OE,
  output logic CONVERSION_CLOCK_TWO_PIN_O,
  output logic CONVERSION_CLOCK_TWO_PIN_OE,
  output logic FRAME_PULSE_PIN_O,
  output logic FRAME_PULSE_PIN_OE,
  // front digital lines
  input wire logic [7:0] DIGITAL_LINE_I,
  input wire logic [7:0] DIGITAL_LINE_VALUE,
  input wire logic [7:0] DIGITAL_LINE_DRIVE_ENABLE,
  output logic [7:0] DIGITAL_LINE_O,
  output logic [7:0] DIGITAL_LINE_OE,
  // sequencer side
  output logic SEQ_CLOCK_ONE,
  output logic SEQ_CLOCK_TWO,
  output logic SEQ_CLOCK_ONE_RISE,
  output logic SEQ_CLOCK_TWO_RISE,
  output logic SEQ_FRAME_EVENT,
  output logic FRAME_TIMER_EVENT
);

  typedef struct packed {
    logic [27:0] div1;
    logic [1:0] sel1;
    logic [27:0] div2;
    logic [1:0] sel2;
    logic fg_csel;
    logic [27:0] interval;
    logic [27:0] count;
    logic en_c1;
    logic en_c2;
    logic en_fg;
    logic [5:0] route;
    logic [5:0] src;
    logic ft_on;
    logic ft_csel;
    logic ft_expired;
    logic ft_run;
    logic [27:0] ft_len;
    logic [27:0] ft_cnt;
    logic ft_event;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync3;
    logic [2:0] seq_lvl;
    logic [2:0] seq_rise;
    logic [2:0] pin_o;
    logic [2:0] pin_oe;
    logic [7:0] line_o;
    logic [7:0] line_oe;
    logic [31:0] rdata;
    logic rvalid;
  } cvsg_top_st_t;

  cvsg_top_st_t s;
  cvsg_top_st_t next_s;
  logic c1_lvl;
  logic c1_rise;
  logic c2_lvl;
  logic c2_rise;
  logic fg_pulse;
  logic fg_rise;
  logic [2:0] gen_lvl;
  logic [2:0] gen_rise;
  logic [31:0] rd_word;
  logic ft_frame;
  logic ft_rise;
  logic ft_expire_now;

  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    hit = (a == off);
  endfunction

  // ==========================================================
  // generators
  cvsg_clkgen u_clk_one (
    .clk(CLK),
    .srst(SRST),
    .on(s.en_c1),
    .ref_sel(s.sel1),
    .divider(s.div1),
    .tick_22(REF_TICK_22),
    .tick_60(REF_TICK_60),
    .level(c1_lvl),
    .rise(c1_rise)
  );

  cvsg_clkgen u_clk_two (
    .clk(CLK),
    .srst(SRST),
    .on(s.en_c2),
    .ref_sel(s.sel2),
    .divider(s.div2),
    .tick_22(REF_TICK_22),
    .tick_60(REF_TICK_60),
    .level(c2_lvl),
    .rise(c2_rise)
  );

  // frame pulses follow the generator output, not the selected source
  assign fg_rise = s.fg_csel ? c2_rise : c1_rise; // RULE_02

  cvsg_framegen u_frame (
    .clk(CLK),
    .srst(SRST),
    .on(s.en_fg),
    .clk_rise(fg_rise),
    .interval(s.interval),
    .count(s.count),
    .pulse(fg_pulse)
  );

  assign gen_lvl = {fg_pulse, c2_lvl, c1_lvl};
  assign gen_rise = {fg_pulse, c2_rise, c1_rise};

  // ==========================================================
  // frame timer inputs, taken from the selected sources
  assign ft_frame = s.seq_rise[2];
  assign ft_rise = s.ft_csel ? s.seq_rise[1] : s.seq_rise[0]; // RULE_14
  assign ft_expire_now = s.ft_on && s.ft_run && ft_rise &&
                         (s.ft_cnt == s.ft_len); // RULE_15

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.ft_event = 1'b0;
    rd_word = 32'h0000_0000;

    // register writes
    if (REG_WR) begin
      if (hit(REG_ADDR, cvsg_pkg::OFF_CLK_ONE)) begin
        next_s.sel1 = REG_WDATA[cvsg_pkg::REF_SEL_LSB +: 2];
        next_s.div1 = REG_WDATA[cvsg_pkg::DIV_W-1:0];
      end
      if (hit(REG_ADDR, cvsg_pkg::OFF_CLK_TWO)) begin
        next_s.sel2 = REG_WDATA[cvsg_pkg::REF_SEL_LSB +: 2];
        next_s.div2 = REG_WDATA[cvsg_pkg::DIV_W-1:0];
      end
      if (hit(REG_ADDR, cvsg_pkg::OFF_INTERVAL)) begin
        next_s.fg_csel = REG_WDATA[cvsg_pkg::FRAME_CLK_SEL_BIT];
        next_s.interval = REG_WDATA[cvsg_pkg::DIV_W-1:0];
      end
      if (hit(REG_ADDR, cvsg_pkg::OFF_COUNT)) begin
        next_s.count = REG_WDATA[cvsg_pkg::DIV_W-1:0];
      end
      if (hit(REG_ADDR, cvsg_pkg::OFF_ENABLES)) begin
        // one write, one edge: both clocks start together
        next_s.en_c1 = REG_WDATA[cvsg_pkg::EN_CLK_ONE_BIT]; // RULE_08
        next_s.en_c2 = REG_WDATA[cvsg_pkg::EN_CLK_TWO_BIT]; // RULE_08
        next_s.en_fg = REG_WDATA[cvsg_pkg::EN_FRAME_BIT];
      end
      if (hit(REG_ADDR, cvsg_pkg::OFF_ROUTING)) begin
        next_s.route = REG_WDATA[5:0];
      end
      if (hit(REG_ADDR, cvsg_pkg::OFF_SOURCE)) begin
        next_s.src = REG_WDATA[5:0];
      end
      if (hit(REG_ADDR, cvsg_pkg::OFF_TIMER)) begin
        next_s.ft_on = REG_WDATA[cvsg_pkg::TIMER_ON_BIT];
        next_s.ft_csel = REG_WDATA[cvsg_pkg::TIMER_CLK_SEL_BIT];
        next_s.ft_len = REG_WDATA[cvsg_pkg::DIV_W-1:0];
      end
    end

    // register reads, unmapped reads give zero
    if (hit(REG_ADDR, cvsg_pkg::OFF_CLK_ONE)) begin
      rd_word = {1'b0, s.sel1, 1'b0, s.div1};
    end else if (hit(REG_ADDR, cvsg_pkg::OFF_CLK_TWO)) begin
      rd_word = {1'b0, s.sel2, 1'b0, s.div2};
    end else if (hit(REG_ADDR, cvsg_pkg::OFF_INTERVAL)) begin
      rd_word = {2'b00, s.fg_csel, 1'b0, s.interval};
    end else if (hit(REG_ADDR, cvsg_pkg::OFF_COUNT)) begin
      rd_word = {4'h0, s.count};
    end else if (hit(REG_ADDR, cvsg_pkg::OFF_ENABLES)) begin
      rd_word = {23'h00_0000, s.en_fg, 6'h00, s.en_c2, s.en_c1};
    end else if (hit(REG_ADDR, cvsg_pkg::OFF_ROUTING)) begin
      rd_word = {26'h000_0000, s.route};
    end else if (hit(REG_ADDR, cvsg_pkg::OFF_SOURCE)) begin
      rd_word = {26'h000_0000, s.src};
    end else if (hit(REG_ADDR, cvsg_pkg::OFF_TIMER)) begin
      rd_word = {s.ft_on, s.ft_csel, s.ft_expired, 1'b0, s.ft_len};
    end
    if (REG_RD) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_word;
    end

    // two stage synchronisers, third stage only for edges
    next_s.sync1 = {DIGITAL_LINE_I[4], DIGITAL_LINE_I[2],
                    DIGITAL_LINE_I[0], FRAME_PULSE_PIN_I,
                    CONVERSION_CLOCK_TWO_PIN_I,
                    CONVERSION_CLOCK_ONE_PIN_I}; // RULE_19
    next_s.sync2 = s.sync1; // RULE_19
    next_s.sync3 = s.sync2;

    // source select and routing per signal
    for (int k = 0; k < 3; k++) begin
      case (s.src[2*k +: 2]) // RULE_12
        cvsg_pkg::SRC_REAR: begin
          next_s.seq_lvl[k] = s.sync2[k];
          next_s.seq_rise[k] = s.sync2[k] & ~s.sync3[k]; // RULE_19
        end
        cvsg_pkg::SRC_FRONT: begin
          next_s.seq_lvl[k] = s.sync2[k+3];
          next_s.seq_rise[k] = s.sync2[k+3] & ~s.sync3[k+3];
        end
        default: begin
          next_s.seq_lvl[k] = gen_lvl[k];
          next_s.seq_rise[k] = gen_rise[k]; // RULE_17
        end
      endcase
      next_s.pin_o[k] = gen_lvl[k];
      next_s.pin_oe[k] = (s.route[2*k +: 2] ==
                          cvsg_pkg::ROUTE_REAR); // RULE_10
    end

    // front lines: plain digital output unless routed with drive enable clear
    next_s.line_o = DIGITAL_LINE_VALUE & DIGITAL_LINE_DRIVE_ENABLE;
    next_s.line_oe = DIGITAL_LINE_DRIVE_ENABLE;
    for (int k = 0; k < 3; k++) begin
      if (!DIGITAL_LINE_DRIVE_ENABLE[2*k] &&
          s.route[2*k +: 2] == cvsg_pkg::ROUTE_FRONT) begin
        next_s.line_o[2*k] = gen_lvl[k]; // RULE_11
        next_s.line_oe[2*k] = 1'b1; // RULE_10
      end
    end

    // frame timer; an expiry in a frame cycle still sets the flag
    if (!s.ft_on) begin
      next_s.ft_run = 1'b0;
      next_s.ft_cnt = 28'h000_0000;
    end else if (ft_frame) begin
      next_s.ft_run = 1'b1; // RULE_13
      next_s.ft_cnt = 28'h000_0000; // RULE_13
    end else if (ft_expire_now) begin
      next_s.ft_run = 1'b0;
    end else if (s.ft_run && ft_rise) begin
      next_s.ft_cnt = s.ft_cnt + 28'h000_0001; // RULE_14
    end
    if (ft_expire_now) begin
      next_s.ft_expired = 1'b1; // RULE_16
      next_s.ft_event = 1'b1; // RULE_16
    end else if (s.ft_on && ft_frame) begin
      next_s.ft_expired = 1'b0; // RULE_16
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      s <= '0;
      s.div1 <= cvsg_pkg::DIV_RST;
      s.div2 <= cvsg_pkg::DIV_RST;
      s.interval <= cvsg_pkg::INTERVAL_RST;
      s.count <= cvsg_pkg::COUNT_RST;
      s.ft_len <= cvsg_pkg::TIMER_LEN_RST;
    end else begin
      s <= next_s;
    end
  end

  assign REG_RDATA = s.rdata;
  assign REG_RVALID = s.rvalid;
  assign CONVERSION_CLOCK_ONE_PIN_O = s.pin_o[0];
  assign CONVERSION_CLOCK_ONE_PIN_OE = s.pin_oe[0];
  assign CONVERSION_CLOCK_TWO_PIN_O = s.pin_o[1];
  assign CONVERSION_CLOCK_TWO_PIN_OE = s.pin_oe[1];
  assign FRAME_PULSE_PIN_O = s.pin_o[2];
  assign FRAME_PULSE_PIN_OE = s.pin_oe[2];
  assign DIGITAL_LINE_O = s.line_o;
  assign DIGITAL_LINE_OE = s.line_oe;
  assign SEQ_CLOCK_ONE = s.seq_lvl[0];
  assign SEQ_CLOCK_TWO = s.seq_lvl[1];
  assign SEQ_CLOCK_ONE_RISE = s.seq_rise[0];
  assign SEQ_CLOCK_TWO_RISE = s.seq_rise[1];
  assign SEQ_FRAME_EVENT = s.seq_rise[2];
  assign FRAME_TIMER_EVENT = s.ft_event;

  // ==========================================================
  // checks
  property p_override;
    @(posedge CLK) disable iff (SRST)
    DIGITAL_LINE_DRIVE_ENABLE[0] |=> DIGITAL_LINE_OE[0] &&
      DIGITAL_LINE_O[0] == $past(DIGITAL_LINE_VALUE[0]);
  endproperty
  a_override: assert property (p_override) // RULE_11
    else $error("drive enable did not override routing");

  property p_rear_route;
    @(posedge CLK) disable iff (SRST)
    s.route[1:0] == cvsg_pkg::ROUTE_REAR && $stable(s.route)
      |-> CONVERSION_CLOCK_ONE_PIN_OE &&
          CONVERSION_CLOCK_ONE_PIN_O == $past(c1_lvl);
  endproperty
  a_rear_route: assert property (p_rear_route) // RULE_10
    else $error("rear pin not driven by generator");

  property p_restart;
    @(posedge CLK) disable iff (SRST)
    s.ft_on && ft_frame |=> s.ft_run && s.ft_cnt == 28'h000_0000;
  endproperty
  a_restart: assert property (p_restart) // RULE_13
    else $error("frame event did not restart timer");

  property p_expire;
    @(posedge CLK) disable iff (SRST)
    ft_expire_now |=> FRAME_TIMER_EVENT && s.ft_expired;
  endproperty
  a_expire: assert property (p_expire) // RULE_15
    else $error("timer expiry not flagged");

  property p_flag_clear;
    @(posedge CLK) disable iff (SRST)
    s.ft_on && ft_frame && !ft_expire_now |=> !s.ft_expired;
  endproperty
  a_flag_clear: assert property (p_flag_clear) // RULE_16
    else $error("expiry flag survived a frame event");

  property p_count_clock;
    @(posedge CLK) disable iff (SRST)
    s.ft_cnt != $past(s.ft_cnt) && s.ft_cnt != 28'h000_0000
      |-> $past(ft_rise);
  endproperty
  a_count_clock: assert property (p_count_clock) // RULE_14
    else $error("timer counted without selected clock");

  property p_sync_start;
    @(posedge CLK) disable iff (SRST)
    REG_WR && hit(REG_ADDR, cvsg_pkg::OFF_ENABLES) &&
      REG_WDATA[1:0] == 2'b11 |=> s.en_c1 && s.en_c2;
  endproperty
  a_sync_start: assert property (p_sync_start) // RULE_08
    else $error("clock enables not taken together");

  property p_rear_sync;
    @(posedge CLK) disable iff (SRST)
    s.src[1:0] == cvsg_pkg::SRC_REAR ##1
      s.src[1:0] == cvsg_pkg::SRC_REAR && s.sync2[0] && !s.sync3[0]
      |=> SEQ_CLOCK_ONE_RISE;
  endproperty
  a_rear_sync: assert property (p_rear_sync) // RULE_19
    else $error("external clock edge not passed on");

  c_expiry: cover property (@(posedge CLK) FRAME_TIMER_EVENT);
  c_frame: cover property (@(posedge CLK) SEQ_FRAME_EVENT);
  c_front: cover property (@(posedge CLK)
    DIGITAL_LINE_OE[2] && !DIGITAL_LINE_DRIVE_ENABLE[2]);

endmodule

//--- tb.sv
// self-checking bench of the conversion signal generator
`timescale 1ns/1ns
module tb;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic run = 1'b0;
  logic frm_in = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [7:0] dval = 8'h00;
  logic [7:0] den = 8'h00;
  logic [31:0] rdata;
  logic [7:0] dlo;
  logic [7:0] dloe;
  logic [7:0] dli;
  logic rvalid, t22, t60, ext, c1oe, r1, r2, frm, tmr;
  logic [2:0] ev;
  int n_mismatch = 0;
  int comparisons = 0;
  int n;
  logic [11:0] offs [9] = '{12'h320, 12'h324, 12'h32c, 12'h330, 12'h33c,
    12'h340, 12'h344, 12'h348, 12'h300};
  logic [27:0] rsv [9] = '{28'hfff_ffff, 28'hfff_ffff, 28'hfff_ffff,
    28'h0, 28'h0, 28'h0, 28'h0, 28'hfff_ffff, 28'h0};

  // undriven front lines are pulled high
  assign dli = (dlo & dloe) | ~dloe;
  assign ev = {tmr, frm, r1};

  initial begin
    forever #25 clk = ~clk;
  end

  cvsg_far_end cvsg_far_end_inst (.clk(clk), .run(run), .tick_22(t22),
    .tick_60(t60), .ext_clk(ext));

  cvsg_top cvsg_top_inst (.CLK(clk), .SRST(srst), .REG_ADDR(addr),
    .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .REF_TICK_22(t22), .REF_TICK_60(t60),
    .CONVERSION_CLOCK_ONE_PIN_I(ext), .CONVERSION_CLOCK_TWO_PIN_I(ext),
    .FRAME_PULSE_PIN_I(frm_in), .CONVERSION_CLOCK_ONE_PIN_O(),
    .CONVERSION_CLOCK_ONE_PIN_OE(c1oe), .CONVERSION_CLOCK_TWO_PIN_O(),
    .CONVERSION_CLOCK_TWO_PIN_OE(), .FRAME_PULSE_PIN_O(),
    .FRAME_PULSE_PIN_OE(), .DIGITAL_LINE_I(dli), .DIGITAL_LINE_VALUE(dval),
    .DIGITAL_LINE_DRIVE_ENABLE(den), .DIGITAL_LINE_O(dlo),
    .DIGITAL_LINE_OE(dloe), .SEQ_CLOCK_ONE(), .SEQ_CLOCK_TWO(),
    .SEQ_CLOCK_ONE_RISE(r1), .SEQ_CLOCK_TWO_RISE(r2),
    .SEQ_FRAME_EVENT(frm), .FRAME_TIMER_EVENT(tmr));

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    comparisons++;
    if (got !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, e);
  endtask

  // cycles to the next pulse of one event, capped at lim
  task automatic gap(input int s, input int lim, input int e);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ev[s] !== 1'b1 && n < lim);
    if (e >= 0)
      chk(n, e);
  endtask

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done;
  end

  // ==========================================================
  // tests
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 9; i++)
      rchk(offs[i], {4'h0, rsv[i]});
    wreg(12'h348, 32'hffff_ffff);
    rchk(12'h348, 32'hcfff_ffff);
    wreg(12'h348, 32'h0000_0000);
    wreg(12'h300, 32'hffff_ffff);
    rchk(12'h300, 32'h0000_0000);
    wreg(12'h33c, 32'h0000_0001);
    for (int r = 0; r < 4; r++) begin
      wreg(12'h320, {1'b0, r[1:0], 29'h3});
      gap(0, 40, -1);
      gap(0, 40, (r == 1) ? -1 : (r == 3) ? 40 : 4);
    end
    wreg(12'h33c, 32'h0000_0000);
    wreg(12'h320, 32'h0000_0003);
    wreg(12'h324, 32'h0000_0003);
    wreg(12'h33c, 32'h0000_0003);
    gap(0, 40, -1);
    chk({31'h0, r2}, 32'h1);
    wreg(12'h320, 32'h0000_0001);
    wreg(12'h32c, 32'h0000_0002);
    wreg(12'h330, 32'h0000_0003);
    wreg(12'h33c, 32'h0000_0101);
    gap(1, 40, -1);
    gap(1, 40, 6);
    gap(1, 40, 6);
    gap(1, 60, 60);
    wreg(12'h33c, 32'h0000_0001);
    wreg(12'h330, 32'h0000_0001);
    wreg(12'h33c, 32'h0000_0101);
    gap(1, 40, -1);
    gap(1, 60, 60);
    wreg(12'h33c, 32'h0000_0001);
    wreg(12'h330, 32'h0000_0000);
    // four rises outlast a three-rise frame, so no expiry
    wreg(12'h348, 32'h8000_0003);
    wreg(12'h33c, 32'h0000_0101);
    gap(1, 40, -1);
    gap(1, 40, 6);
    gap(2, 60, 60);
    wreg(12'h348, 32'h8000_0001);
    gap(2, 40, -1);
    chk({31'h0, n < 40}, 32'h1);
    wreg(12'h33c, 32'h0000_0001);
    // let a frame pulse still in flight clear and re-arm the flag
    repeat (8) @(posedge clk);
    rchk(12'h348, 32'ha000_0001);
    wreg(12'h344, 32'h0000_0020);
    wreg(12'h348, 32'h8000_0007);
    frm_in <= 1'b1;
    repeat (2) @(posedge clk);
    frm_in <= 1'b0;
    gap(1, 10, -1);
    rchk(12'h348, 32'h8000_0007);
    wreg(12'h340, 32'h0000_0002);
    repeat (3) @(posedge clk);
    #1;
    chk({31'h0, c1oe}, 32'h1);
    wreg(12'h340, 32'h0000_0003);
    repeat (3) @(posedge clk);
    #1;
    chk({30'h0, dloe[0], c1oe}, 32'h2);
    @(posedge clk);
    den <= 8'h01;
    repeat (8) begin
      @(posedge clk);
      #1;
      chk({31'h0, dlo[0]}, 32'h0);
    end
    wreg(12'h344, 32'h0000_0002);
    run <= 1'b1;
    gap(0, 40, -1);
    gap(0, 40, 8);
    test_done;
  end
endmodule
